// ===== hw/pcl_loader.sv
// Configuration loader: parallel, serial and test-port loading, start-up
// Summary of operation
// - In user mode a low request line starts a reconfiguration cycle.
// - Status line is held low for the whole power-on-reset delay.
// - Done output stays low after power-up and during configuration, except for the final byte in parallel mode.
// - After configuration the eight data pins act as user I/O per dual-purpose setting.
// - Done goes low within 500 ns of request going low.
// - Status goes low within 500 ns of request going low, except during a test-port load.
// - Status low pulse lasts 45 to 230 us unless the host stretches it.
// - Status released at most 230 us after request returns high.
// - With internal oscillator, user mode 300 to 650 us after done rises.
// - User init clock enabled only 4 max byte clock periods after done.
// - With user clock option, user mode after enable delay plus init cycles.
// - Test-port configuration overrides and aborts any other load at once.
// - In active serial mode the byte clock is not driven during test-port loading.
// - Secure variant refuses test-port programming after serial load; mandatory only.
// - TDI sampled on rising TCK.
// - TDO changes on falling TCK and floats when not shifting.
// - TAP evaluates TMS and moves only on rising TCK.
// - All user I/O pins float during test-port configuration.
// - Each byte captured on rising byte clock until done rises.
// - In parallel mode done rises one byte before the final byte.
`default_nettype none
`include "pcl_regs.svh"
module pcl_loader #(
  parameter int unsigned IMAGE_BYTES     = 1024,
  parameter int unsigned POR_CYCLES      = 4000,
  parameter int unsigned CD2UM_CYCLES    = `PCL_CD2UM_CYC,
  parameter int unsigned INIT_CLK_CYCLES = 3000,
  parameter int unsigned USER_IO_W       = 16,
  parameter bit          SECURE_VARIANT  = 1'b0
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 config_request_n_i,
  input  wire logic                 config_status_n_i,
  output logic                      config_status_n_o,
  output logic                      config_status_n_oe_o,
  output logic                      config_complete_o,
  input  wire logic                 byte_load_clock_i,
  output logic                      byte_load_clock_o,
  output logic                      byte_load_clock_oe_o,
  input  wire logic [7:0]           data_i,
  output logic      [7:0]           data_o,
  output logic      [7:0]           data_oe_o,
  input  wire logic                 dual_purpose_drive_i,
  input  wire logic [7:0]           user_data_i,
  input  wire logic [1:0]           load_mode_select_i,
  input  wire logic                 user_init_clock_i,
  input  wire logic                 use_user_clock_i,
  input  wire logic                 auto_restart_i,
  input  wire logic                 load_error_i,
  input  wire logic                 tck_i,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  output logic                      tdo_o,
  output logic                      tdo_oe_o,
  input  wire logic [USER_IO_W-1:0] user_io_oe_i,
  output logic      [USER_IO_W-1:0] user_io_oe_o,
  output logic      [7:0]           cfg_byte_o,
  output logic                      cfg_byte_valid_o,
  output logic                      user_mode_o
);
  import pcl_pkg::*;

  localparam logic [15:0] HOLD_LAST = 16'(`PCL_STATUS_HOLD_CYC - 1);
  localparam logic [15:0] POR_LAST  = 16'(POR_CYCLES - 1);
  localparam logic [15:0] UM_LAST   = 16'(CD2UM_CYCLES - 1);
  localparam logic [15:0] CU_LAST   = 16'(`PCL_CD2CU_CYC - 1);
  localparam logic [15:0] UCLK_LAST = 16'(INIT_CLK_CYCLES);
  localparam logic [31:0] FAST_LAST = 32'(IMAGE_BYTES - 1);
  localparam logic [31:0] SER_LAST  = 32'(IMAGE_BYTES);

  pcl_reg_t s_q;
  pcl_reg_t s_d;

  logic       req;
  logic       ext_sts;
  logic       byte_load_clock_rise;
  logic       byte_load_clock_fall;
  logic       uclk_rise;
  logic       tck_rise;
  logic       tck_fall;
  logic       tms;
  logic       tdi;
  logic [7:0] din;
  logic [1:0] load_mode_select;
  logic       prog_ir;
  logic       shifting;

  // Only second stages and the edge history are read
  assign req       = s_q.req_s[1];
  assign ext_sts   = s_q.sts_s[1];
  assign byte_load_clock_rise = s_q.byte_load_clock_s[1] & ~s_q.byte_load_clock_s[2];
  assign byte_load_clock_fall = ~s_q.byte_load_clock_s[1] & s_q.byte_load_clock_s[2];
  assign uclk_rise = s_q.uclk_s[1] & ~s_q.uclk_s[2];
  assign tck_rise  = s_q.tck_s[1] & ~s_q.tck_s[2];
  assign tck_fall  = ~s_q.tck_s[1] & s_q.tck_s[2];
  assign tms       = s_q.tms_s[1];
  assign tdi       = s_q.tdi_s[1];
  assign din       = s_q.data_s[15:8];
  assign load_mode_select      = s_q.load_mode_select_s[3:2];
  assign prog_ir   = (s_q.ir == `PCL_IR_PROGRAM);
  assign shifting  = (s_q.tap == TAP_SHDR) || (s_q.tap == TAP_SHIR);

  function automatic logic ir_allowed(input logic [3:0] code, input logic ser);
    logic mand;
    mand = (code == `PCL_IR_BYPASS) || (code == `PCL_IR_EXTEST) ||
           (code == `PCL_IR_SAMPLE);
    if (!SECURE_VARIANT) begin
      ir_allowed = 1'b1;
    end else begin
      ir_allowed = mand || ((code == `PCL_IR_PROGRAM) && !ser);
    end
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.req_s  = {s_q.req_s[0], config_request_n_i};
    s_d.sts_s  = {s_q.sts_s[0], config_status_n_i};
    s_d.byte_load_clock_s = {s_q.byte_load_clock_s[1:0], byte_load_clock_i};
    s_d.data_s = {s_q.data_s[7:0], data_i};
    s_d.uclk_s = {s_q.uclk_s[1:0], user_init_clock_i};
    s_d.load_mode_select_s = {s_q.load_mode_select_s[1:0], load_mode_select_i};
    s_d.tck_s  = {s_q.tck_s[1:0], tck_i};
    s_d.tms_s  = {s_q.tms_s[0], tms_i};
    s_d.tdi_s  = {s_q.tdi_s[0], tdi_i};
    s_d.byte_v = 1'b0;
    s_d.udata  = user_data_i;
    s_d.asclk  = 1'b0;

    // Test access port; all movement on rising TCK only
    if (tck_rise) begin
      case (s_q.tap)
        TAP_RESET: s_d.tap = tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE:  s_d.tap = tms ? TAP_SELDR : TAP_IDLE;
        TAP_SELDR: s_d.tap = tms ? TAP_SELIR : TAP_CAPDR;
        TAP_CAPDR: s_d.tap = tms ? TAP_EX1DR : TAP_SHDR;
        TAP_SHDR:  s_d.tap = tms ? TAP_EX1DR : TAP_SHDR;
        TAP_EX1DR: s_d.tap = tms ? TAP_UPDR : TAP_PSDR;
        TAP_PSDR:  s_d.tap = tms ? TAP_EX2DR : TAP_PSDR;
        TAP_EX2DR: s_d.tap = tms ? TAP_UPDR : TAP_SHDR;
        TAP_UPDR:  s_d.tap = tms ? TAP_SELDR : TAP_IDLE;
        TAP_SELIR: s_d.tap = tms ? TAP_RESET : TAP_CAPIR;
        TAP_CAPIR: s_d.tap = tms ? TAP_EX1IR : TAP_SHIR;
        TAP_SHIR:  s_d.tap = tms ? TAP_EX1IR : TAP_SHIR;
        TAP_EX1IR: s_d.tap = tms ? TAP_UPIR : TAP_PSIR;
        TAP_PSIR:  s_d.tap = tms ? TAP_EX2IR : TAP_PSIR;
        TAP_EX2IR: s_d.tap = tms ? TAP_UPIR : TAP_SHIR;
        TAP_UPIR:  s_d.tap = tms ? TAP_SELDR : TAP_IDLE;
        default:   s_d.tap = TAP_RESET;
      endcase
      case (s_q.tap)
        TAP_RESET: s_d.ir = `PCL_IR_BYPASS;
        TAP_CAPIR: s_d.ir_sh = 4'h1;
        TAP_SHIR:  s_d.ir_sh = {tdi, s_q.ir_sh[3:1]};
        TAP_UPIR: begin
          // Refused codes fall back to bypass
          if (ir_allowed(s_q.ir_sh, s_q.serial_cfg)) begin
            s_d.ir = s_q.ir_sh;
          end else begin
            s_d.ir = `PCL_IR_BYPASS;
          end
          if ((s_q.ir_sh == `PCL_IR_PROGRAM) && ir_allowed(s_q.ir_sh, s_q.serial_cfg)) begin
            // Overrides any load under way, even mid-image
            s_d.st      = PCL_JTAG;
            s_d.bytes   = 32'h0;
            s_d.bitn    = 3'h0;
            s_d.done    = 1'b0;
            s_d.sts_low = 1'b0;
          end
        end
        TAP_CAPDR: s_d.byp = 1'b0;
        TAP_SHDR: begin
          if (prog_ir && s_q.st == PCL_JTAG) begin
            s_d.sh   = {tdi, s_q.sh[7:1]};
            s_d.bitn = s_q.bitn + 3'h1;
            if (s_q.bitn == 3'h7) begin
              s_d.byte_q = {tdi, s_q.sh[7:1]};
              s_d.byte_v = 1'b1;
              s_d.bytes  = s_q.bytes + 32'h1;
            end
          end else begin
            s_d.byp = tdi;
          end
        end
        default: s_d.ir = s_d.ir;
      endcase
    end
    if (tck_fall) begin
      s_d.tdo_oe = shifting;
      if (s_q.tap == TAP_SHIR) begin
        s_d.tdo = s_q.ir_sh[0];
      end else if (prog_ir) begin
        s_d.tdo = s_q.sh[0];
      end else begin
        s_d.tdo = s_q.byp;
      end
    end

    case (s_q.st)
      PCL_POR: begin
        s_d.sts_low = 1'b1;
        s_d.done    = 1'b0;
        s_d.cnt     = s_q.cnt + 16'h1;
        if (s_q.cnt >= POR_LAST) begin
          s_d.sts_low = 1'b0;
          s_d.st      = PCL_LOAD;
          s_d.bytes   = 32'h0;
          s_d.bitn    = 3'h0;
        end
      end
      PCL_RESET, PCL_ERROR: begin
        // Count from request high so release stays inside the 230 us bound
        s_d.cnt = req ? s_q.cnt + 16'h1 : 16'h0;
        if (s_q.sts_low && req && s_q.cnt >= HOLD_LAST) begin
          s_d.sts_low = 1'b0;
          if (s_q.st == PCL_RESET || auto_restart_i) begin
            s_d.st    = PCL_LOAD;
            s_d.bytes = 32'h0;
            s_d.bitn  = 3'h0;
          end
        end
      end
      PCL_LOAD: begin
        s_d.cnt = 16'h0;
        if (load_error_i) begin
          s_d.st      = PCL_ERROR;
          s_d.sts_low = 1'b1;
        end else if (ext_sts) begin
          // Bus held low by another party stretches the wait
          if (load_mode_select == `PCL_MODE_FAST) begin
            if (byte_load_clock_rise) begin
              s_d.byte_q = din;
              s_d.byte_v = 1'b1;
              s_d.bytes  = s_q.bytes + 32'h1;
              if (s_q.bytes + 32'h1 >= FAST_LAST) begin
                s_d.done  = 1'b1;
                s_d.st    = PCL_INIT;
                s_d.falls = 2'h0;
              end
            end
          end else begin
            s_d.asclk = (load_mode_select == `PCL_MODE_ACTIVE) ? ~s_q.asclk : 1'b0;
            if ((load_mode_select == `PCL_MODE_ACTIVE) ? (s_d.asclk & ~s_q.asclk) : byte_load_clock_rise) begin
              s_d.sh   = {din[0], s_q.sh[7:1]};
              s_d.bitn = s_q.bitn + 3'h1;
              if (s_q.bitn == 3'h7) begin
                s_d.byte_q = {din[0], s_q.sh[7:1]};
                s_d.byte_v = 1'b1;
                s_d.bytes  = s_q.bytes + 32'h1;
                if (s_q.bytes + 32'h1 >= SER_LAST) begin
                  s_d.done       = 1'b1;
                  s_d.serial_cfg = 1'b1;
                  s_d.st         = PCL_INIT;
                  s_d.falls      = 2'h0;
                end
              end
            end
          end
        end
      end
      PCL_JTAG: begin
        s_d.cnt = 16'h0;
        if (s_q.bytes >= SER_LAST) begin
          s_d.done  = 1'b1;
          s_d.st    = PCL_INIT;
          s_d.falls = 2'h2;
        end
      end
      PCL_INIT: begin
        s_d.cnt = s_q.cnt + 16'h1;
        if (byte_load_clock_fall && s_q.falls != 2'h2) begin
          s_d.falls = s_q.falls + 2'h1;
        end
        if (use_user_clock_i) begin
          if (s_q.cnt >= CU_LAST) begin
            s_d.uclk_en = 1'b1;
          end
          if (s_q.uclk_en && uclk_rise) begin
            s_d.ucnt = s_q.ucnt + 16'h1;
          end
          if (s_q.ucnt >= UCLK_LAST && s_q.falls == 2'h2) begin
            s_d.st = PCL_USER;
          end
        end else if (s_q.cnt >= UM_LAST && s_q.falls == 2'h2) begin
          s_d.st = PCL_USER;
        end
      end
      PCL_USER: s_d.cnt = 16'h0;
      default:  s_d.st = PCL_POR;
    endcase
    if (s_d.st != PCL_INIT) begin
      s_d.uclk_en = 1'b0;
      s_d.ucnt    = 16'h0;
    end

    // Request low aborts everything but a test-port load or the power-on delay
    if (!req && s_q.st != PCL_JTAG && s_q.st != PCL_POR) begin
      s_d.st      = PCL_RESET;
      s_d.sts_low = 1'b1;
      s_d.done    = 1'b0;
      s_d.cnt     = 16'h0;
      s_d.byte_v  = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q        <= '0;
      s_q.req_s  <= 2'h3;
      s_q.sts_s  <= 2'h3;
      s_q.sts_low <= 1'b1;
      s_q.st     <= PCL_POR;
      s_q.tap    <= TAP_RESET;
      s_q.ir     <= `PCL_IR_BYPASS;
    end else begin
      s_q <= s_d;
    end
  end

  assign config_status_n_o    = 1'b0;
  assign config_status_n_oe_o = s_q.sts_low;
  assign config_complete_o    = s_q.done;
  assign byte_load_clock_o    = s_q.asclk;
  // Active serial clock silent whenever test port owns the load
  assign byte_load_clock_oe_o = (s_q.st == PCL_LOAD) && (load_mode_select == `PCL_MODE_ACTIVE);
  assign data_o               = s_q.udata;
  assign data_oe_o            = {8{(s_q.st == PCL_USER) && dual_purpose_drive_i}};
  assign user_io_oe_o         = (s_q.st == PCL_USER) ? user_io_oe_i : '0;
  assign tdo_o                = s_q.tdo;
  assign tdo_oe_o             = s_q.tdo_oe;
  assign cfg_byte_o           = s_q.byte_q;
  assign cfg_byte_valid_o     = s_q.byte_v;
  assign user_mode_o          = (s_q.st == PCL_USER);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  status_on_req_a: assert property ($fell(req) && $past(s_q.st) != PCL_POR && s_q.st != PCL_JTAG |=> config_status_n_oe_o) else $error("status not low after request");
  done_on_req_a: assert property ($fell(config_request_n_i) && s_q.st == PCL_USER |-> ##[1:4] !config_complete_o) else $error("done not low after request");
  por_hold_a: assert property (s_q.st == PCL_POR |-> config_status_n_oe_o && !config_complete_o) else $error("status or done wrong in power-on delay");
  load_done_low_a: assert property (s_q.st == PCL_LOAD |-> !config_complete_o) else $error("done high during load");
  status_pulse_a: assert property ($fell(s_q.sts_low) && $past(s_q.st) == PCL_RESET |-> $past(s_q.cnt) == HOLD_LAST) else $error("status pulse length wrong");
  fast_done_a: assert property ($rose(s_q.done) && $past(s_q.st) == PCL_LOAD && $past(load_mode_select) == `PCL_MODE_FAST |-> s_q.bytes == FAST_LAST) else $error("done not one byte early");
  user_delay_a: assert property ($rose(user_mode_o) && !use_user_clock_i |-> $past(s_q.cnt) >= UM_LAST) else $error("user mode too early");
  uclk_enable_a: assert property ($rose(s_q.uclk_en) |-> $past(s_q.cnt) >= CU_LAST && s_q.st == PCL_INIT) else $error("user clock enabled too early");
  jtag_float_a: assert property (s_q.st == PCL_JTAG |-> user_io_oe_o == '0 && !byte_load_clock_oe_o && data_oe_o == 8'h00) else $error("pins driven during test-port load");
  tdo_edge_a: assert property ($changed(tdo_oe_o) |-> $past(tck_fall)) else $error("tdo enable moved off falling edge");
endmodule
`default_nettype wire

// ===== inc/pcl_regs.svh
// Timing constants, instruction codes and mode codes of the parallel configuration loader
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH
`define PCL_MCLK_MHZ        40
`define PCL_T_CF2ST_NS      500
`define PCL_T_STATUS_MIN_US 45
`define PCL_T_STATUS_MAX_US 230
`define PCL_T_CD2UM_MIN_US  300
`define PCL_T_CD2UM_MAX_US  650
`define PCL_T_BYTE_LOAD_CLOCK_MAX_NS   10
`define PCL_CD2CU_MULT      4
`define PCL_CF2ST_CYC       ((`PCL_T_CF2ST_NS * `PCL_MCLK_MHZ) / 1000)
`define PCL_STATUS_HOLD_CYC (`PCL_T_STATUS_MIN_US * `PCL_MCLK_MHZ)
`define PCL_CD2UM_CYC       (`PCL_T_CD2UM_MIN_US * `PCL_MCLK_MHZ)
`define PCL_CD2CU_CYC       ((`PCL_CD2CU_MULT * `PCL_T_BYTE_LOAD_CLOCK_MAX_NS * `PCL_MCLK_MHZ + 999) / 1000)
`define PCL_IR_BYPASS       4'hF
`define PCL_IR_EXTEST       4'h0
`define PCL_IR_SAMPLE       4'h5
`define PCL_IR_PROGRAM      4'h2
`define PCL_MODE_FAST       2'h0
`define PCL_MODE_PASSIVE    2'h1
`define PCL_MODE_ACTIVE     2'h2
`endif

// ===== inc/pcl_pkg.sv
// Types of the parallel configuration loader
`default_nettype none
package pcl_pkg;
  typedef enum logic [6:0] {
    PCL_POR   = 7'h01,
    PCL_RESET = 7'h02,
    PCL_LOAD  = 7'h04,
    PCL_INIT  = 7'h08,
    PCL_USER  = 7'h10,
    PCL_JTAG  = 7'h20,
    PCL_ERROR = 7'h40
  } pcl_state_t;
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE  = 16'h0002, TAP_SELDR = 16'h0004, TAP_CAPDR = 16'h0008,
    TAP_SHDR  = 16'h0010, TAP_EX1DR = 16'h0020, TAP_PSDR  = 16'h0040, TAP_EX2DR = 16'h0080,
    TAP_UPDR  = 16'h0100, TAP_SELIR = 16'h0200, TAP_CAPIR = 16'h0400, TAP_SHIR  = 16'h0800,
    TAP_EX1IR = 16'h1000, TAP_PSIR  = 16'h2000, TAP_EX2IR = 16'h4000, TAP_UPIR  = 16'h8000
  } pcl_tap_t;
  typedef struct packed {
    logic [1:0]  req_s;
    logic [1:0]  sts_s;
    logic [2:0]  byte_load_clock_s;
    logic [15:0] data_s;
    logic [2:0]  uclk_s;
    logic [3:0]  load_mode_select_s;
    logic [2:0]  tck_s;
    logic [1:0]  tms_s;
    logic [1:0]  tdi_s;
    pcl_state_t  st;
    pcl_tap_t    tap;
    logic [15:0] cnt;
    logic [31:0] bytes;
    logic [1:0]  falls;
    logic [15:0] ucnt;
    logic        uclk_en;
    logic [3:0]  ir_sh;
    logic [3:0]  ir;
    logic [7:0]  sh;
    logic [2:0]  bitn;
    logic        byp;
    logic        tdo;
    logic        tdo_oe;
    logic [7:0]  byte_q;
    logic        byte_v;
    logic        done;
    logic        sts_low;
    logic        serial_cfg;
    logic        asclk;
    logic [7:0]  udata;
  } pcl_reg_t;
endpackage
`default_nettype wire

// ===== verif/pcl_host.sv
// Host model driving the request, byte clock and data pins
`default_nettype none
module pcl_host (
  input  wire logic       mclk_i,
  input  wire logic       status_n_i,
  output logic            request_n_o,
  output logic            byte_clock_o,
  output logic [7:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    request_n_o  = 1'b1;
    byte_clock_o = 1'b0;
    data_o       = 8'h00;
  end

  // Callers are always at a falling edge of mclk_i
  task automatic idle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Never shorter than 500 ns, whatever the caller asks
  task automatic request_pulse(input int n);
    request_n_o = 1'b0;
    idle((n < 20) ? 20 : n);
    request_n_o = 1'b1;
  endtask

  task automatic wait_ready(output int n);
    for (n = 0; n < 12000 && status_n_i !== 1'b1; n++) idle(1);
    idle(80);
  endtask

  // Data changes only with the falling edge, stable 4 cycles either side
  task automatic send_byte(input logic [7:0] b);
    byte_clock_o = 1'b0;
    data_o       = b;
    idle(4);
    byte_clock_o = 1'b1;
    idle(4);
  endtask

  task automatic finish();
    byte_clock_o = 1'b0;
    idle(4);
    byte_clock_o = 1'b1;
    idle(4);
    byte_clock_o = 1'b0;
    data_o       = ~data_o;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_pcl_loader.sv
// Self-checking bench of the configuration loader
`default_nettype none
`include "pcl_regs.svh"
module tb_pcl_loader;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NB = 8;
  localparam int unsigned POR = 50;
  localparam int unsigned UM = 200;
  localparam int unsigned ICK = 8;

  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        req_n, host_clk, sts_w, sts_o, sts_oe, done, bclk_w, bclk_o, bclk_oe;
  logic [7:0]  host_d, data_w, d_o, d_oe, cbyte;
  logic        dual = 1'b1;
  logic [7:0]  udata = 8'h00;
  logic [1:0]  load_mode_select = 2'h0;
  logic        uclk = 1'b0;
  logic        use_uclk = 1'b0;
  logic        auto_rst = 1'b0;
  logic        load_err = 1'b0;
  logic        tck = 1'b0;
  logic        tms = 1'b1;
  logic        tdi = 1'b1;
  logic        tdo, tdo_oe, cvalid, umode;
  logic [15:0] uio_oe = 16'hFFFF;
  logic [15:0] uio_oe_o;
  logic [7:0]  expq[$];
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          seed;
  int          n;

  always #12.5 mclk = ~mclk;

  // Pull-up on the open-drain status wire; shared pins resolved by enable
  assign sts_w  = sts_oe ? sts_o : 1'b1;
  assign bclk_w = bclk_oe ? bclk_o : host_clk;
  assign data_w = (d_oe & d_o) | (~d_oe & host_d);

  pcl_host host_i (
    .mclk_i       (mclk),
    .status_n_i   (sts_w),
    .request_n_o  (req_n),
    .byte_clock_o (host_clk),
    .data_o       (host_d)
  );

  pcl_loader #(
    .IMAGE_BYTES     (NB),
    .POR_CYCLES      (POR),
    .CD2UM_CYCLES    (UM),
    .INIT_CLK_CYCLES (ICK),
    .USER_IO_W       (16),
    .SECURE_VARIANT  (1'b0)
  ) pcl_loader_i (
    .mclk_i               (mclk),
    .rst_i                (rst),
    .config_request_n_i   (req_n),
    .config_status_n_i    (sts_w),
    .config_status_n_o    (sts_o),
    .config_status_n_oe_o (sts_oe),
    .config_complete_o    (done),
    .byte_load_clock_i    (bclk_w),
    .byte_load_clock_o    (bclk_o),
    .byte_load_clock_oe_o (bclk_oe),
    .data_i               (data_w),
    .data_o               (d_o),
    .data_oe_o            (d_oe),
    .dual_purpose_drive_i (dual),
    .user_data_i          (udata),
    .load_mode_select_i   (load_mode_select),
    .user_init_clock_i    (uclk),
    .use_user_clock_i     (use_uclk),
    .auto_restart_i       (auto_rst),
    .load_error_i         (load_err),
    .tck_i                (tck),
    .tms_i                (tms),
    .tdi_i                (tdi),
    .tdo_o                (tdo),
    .tdo_oe_o             (tdo_oe),
    .user_io_oe_i         (uio_oe),
    .user_io_oe_o         (uio_oe_o),
    .cfg_byte_o           (cbyte),
    .cfg_byte_valid_o     (cvalid),
    .user_mode_o          (umode)
  );

  task automatic conclude();
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Oldest noted byte against every captured byte, mid-cycle where it is settled
  always @(negedge mclk) begin
    if (cvalid === 1'b1) begin
      if (expq.size() == 0) cmp_bit(1'b1, 1'b0, "unexpected byte");
      else cmp_byte(cbyte, expq.pop_front(), "captured byte");
    end
  end

  // Bound is nearly three times the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      conclude();
    end
  end

  task automatic uclk_pulses(input int k);
    repeat (k) begin
      uclk = 1'b1;
      repeat (4) @(negedge mclk);
      uclk = 1'b0;
      repeat (4) @(negedge mclk);
    end
  endtask

  task automatic load(input logic uck, input logic dp);
    int w;
    logic [7:0] b;
    use_uclk = uck;
    dual     = dp;
    udata    = 8'($urandom);
    host_i.wait_ready(w);
    cmp_bit(sts_w, 1'b1, "status stuck low");
    for (int i = 0; i < NB; i++) begin
      b = 8'($urandom);
      if (i < NB - 1) expq.push_back(b);
      if (i == NB - 2) cmp_bit(done, 1'b0, "done early");
      host_i.send_byte(b);
    end
    cmp_bit(done, 1'b1, "done not one byte early");
    host_i.finish();
    if (uck) begin
      uclk_pulses(ICK - 2);
      cmp_bit(umode, 1'b0, "user mode before init clocks");
      uclk_pulses(4);
    end else begin
      repeat (UM - 60) @(negedge mclk);
      cmp_bit(umode, 1'b0, "user mode too early");
      repeat (80) @(negedge mclk);
    end
    cmp_bit(umode, 1'b1, "user mode missing");
    cmp_byte(d_oe, {8{dp}}, "data pin enables");
    cmp_byte(d_o, udata, "user data out");
  endtask

  task automatic reconfig(input logic [1:0] mode);
    int w;
    load_mode_select = mode;
    fork
      host_i.request_pulse(24);
      begin
        repeat (20) @(negedge mclk);
        cmp_bit(done, 1'b0, "done not cleared");
        cmp_bit(sts_oe, 1'b1, "status not pulled");
        cmp_bit(umode, 1'b0, "still in user mode");
      end
    join
    for (w = 0; w < 9400 && sts_w !== 1'b1; w++) @(negedge mclk);
    cmp_bit(w <= 9200, 1'b1, "status release late");
    cmp_bit(w + 24 >= 1800, 1'b1, "status pulse short");
    host_i.idle(9200 - w);
  endtask

  // Error during load with auto-restart: status pulse, then back to load
  task automatic error_restart();
    int w;
    auto_rst = 1'b1;
    load_err = 1'b1;
    @(negedge mclk);
    load_err = 1'b0;
    @(negedge mclk);
    cmp_bit(sts_oe, 1'b1, "status not pulled on error");
    for (w = 0; w < 9400 && sts_w !== 1'b1; w++) @(negedge mclk);
    cmp_bit(w <= 9200, 1'b1, "error release late");
    cmp_bit(w + 2 >= 1800, 1'b1, "error pulse short");
    auto_rst = 1'b0;
  endtask

  task automatic tck_bit(input logic s, input logic d);
    tms = s;
    tdi = d;
    repeat (4) @(negedge mclk);
    tck = 1'b1;
    repeat (4) @(negedge mclk);
    tck = 1'b0;
  endtask

  task automatic tms_walk(input logic [15:0] pat, input int k);
    for (int i = 0; i < k; i++) tck_bit(pat[i], 1'b1);
  endtask

  task automatic jtag_load();
    logic [7:0] b;
    logic [3:0] ir;
    ir = `PCL_IR_PROGRAM;
    tms_walk(16'h00DF, 10);
    for (int k = 0; k < 4; k++) tck_bit(k == 3, ir[k]);
    tms_walk(16'h0001, 2);
    repeat (4) @(negedge mclk);
    cmp_bit(done, 1'b0, "done during test-port load");
    cmp_bit(|uio_oe_o, 1'b0, "user io driven");
    tms_walk(16'h0001, 3);
    for (int i = 0; i < NB; i++) begin
      b = 8'($urandom);
      expq.push_back(b);
      for (int k = 0; k < 8; k++) tck_bit(i == NB - 1 && k == 7, b[k]);
      if (i == 0) begin
        repeat (4) @(negedge mclk);
        cmp_bit(tdo_oe, 1'b1, "tdo idle while shifting");
        cmp_bit(tdo, b[0], "tdo data");
      end
    end
    tms_walk(16'h0001, 2);
    repeat (8) @(negedge mclk);
    cmp_bit(tdo_oe, 1'b0, "tdo driven outside shift");
    cmp_bit(done, 1'b1, "test-port load not complete");
    cmp_bit(expq.size() == 0, 1'b1, "bytes missing");
  endtask

  initial begin
    seed = $urandom(18782);
    uio_oe = 16'($urandom) | 16'h0001;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (40) @(negedge mclk);
    cmp_bit(sts_oe, 1'b1, "status released early");
    cmp_bit(done, 1'b0, "done high after reset");
    load(1'b0, 1'b1);
    reconfig(2'h0);
    error_restart();
    load(1'b1, 1'b0);
    reconfig(2'h1);
    host_i.wait_ready(n);
    for (int i = 0; i < 3; i++) host_i.send_byte(8'h01);
    jtag_load();
    conclude();
  end
endmodule
`default_nettype wire
